// *** rtl/cafr_pkg.sv ***
// Constants and types shared by the datapath core files
package cafr_pkg;

    localparam int NUM_REGS = 32;

    localparam logic [15:0] ADDR_REG_LAST   = 16'h001F;
    localparam logic [15:0] ADDR_FLAGS_DATA = 16'h005F;
    localparam logic [15:0] ADDR_PORT_OFS   = 16'h0020;
    localparam logic [15:0] ADDR_EXT_FIRST  = 16'h0060;
    localparam logic [5:0]  PORT_LAST       = 6'h3F;

    localparam logic [7:0]  FLAGS_RESET = 8'h00;

    localparam int FLAG_I = 7;
    localparam int FLAG_T = 6;
    localparam int FLAG_H = 5;
    localparam int FLAG_S = 4;
    localparam int FLAG_V = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;

    localparam logic [4:0] PTR_A_LOW = 5'h1A;
    localparam logic [4:0] PTR_B_LOW = 5'h1C;
    localparam logic [4:0] PTR_C_LOW = 5'h1E;

    typedef enum logic [3:0] {
        CAFR_OP_ADD,
        CAFR_OP_ADC,
        CAFR_OP_SUB,
        CAFR_OP_SBC,
        CAFR_OP_AND,
        CAFR_OP_OR,
        CAFR_OP_XOR,
        CAFR_OP_MOV,
        CAFR_OP_INC,
        CAFR_OP_DEC,
        CAFR_OP_COM,
        CAFR_OP_NEG,
        CAFR_OP_LSR,
        CAFR_OP_ROR,
        CAFR_OP_ASR,
        CAFR_OP_SWAP
    } cafr_op_t;

    typedef enum logic [1:0] {
        CAFR_PTR_A,
        CAFR_PTR_B,
        CAFR_PTR_C,
        CAFR_PTR_NONE
    } cafr_ptr_t;

    typedef enum logic [1:0] {
        CAFR_PM_DISP,
        CAFR_PM_POSTINC,
        CAFR_PM_PREDEC
    } cafr_ptrmode_t;

endpackage : cafr_pkg

// *** rtl/cafr_alu.sv ***
// Combinational arithmetic unit with flag generation
`timescale 1ns/1ps

module cafr_alu
    import cafr_pkg::*;
(
    input  wire cafr_op_t   op,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic [7:0] flags_in,
    output logic      [7:0] result,
    output logic      [7:0] flags_out
);

    logic [8:0] sum;
    logic       hc;
    logic       ov;
    logic       cy;
    logic       keep_z;
    logic       def_h;

    always_comb begin
        sum    = 9'h000;
        hc     = 1'b0;
        ov     = 1'b0;
        cy     = flags_in[FLAG_C];
        keep_z = 1'b0;
        def_h  = 1'b0;
        result = a;
        unique case (op)
            CAFR_OP_ADD, CAFR_OP_ADC: begin
                sum = {1'b0, a} + {1'b0, b}
                    + {8'h00, (op == CAFR_OP_ADC) & flags_in[FLAG_C]};
                result = sum[7:0];
                cy     = sum[8];
                hc     = (a[3] & b[3]) | (b[3] & ~result[3])
                       | (~result[3] & a[3]);
                ov     = (a[7] & b[7] & ~result[7])
                       | (~a[7] & ~b[7] & result[7]);
                def_h  = 1'b1;
            end
            CAFR_OP_SUB, CAFR_OP_SBC: begin
                sum = {1'b0, a} - {1'b0, b}
                    - {8'h00, (op == CAFR_OP_SBC) & flags_in[FLAG_C]};
                result = sum[7:0];
                cy     = sum[8];
                hc     = (~a[3] & b[3]) | (b[3] & result[3])
                       | (result[3] & ~a[3]);
                ov     = (a[7] & ~b[7] & ~result[7])
                       | (~a[7] & b[7] & result[7]);
                def_h  = 1'b1;
                // Carry-chained subtract keeps zero only if still zero
                keep_z = (op == CAFR_OP_SBC);
            end
            CAFR_OP_AND: result = a & b;
            CAFR_OP_OR:  result = a | b;
            CAFR_OP_XOR: result = a ^ b;
            CAFR_OP_MOV: result = b;
            CAFR_OP_INC: begin
                result = a + 8'h01;
                ov     = (a == 8'h7F);
            end
            CAFR_OP_DEC: begin
                result = a - 8'h01;
                ov     = (a == 8'h80);
            end
            CAFR_OP_COM: begin
                result = ~a;
                cy     = 1'b1;
            end
            CAFR_OP_NEG: begin
                result = 8'h00 - a;
                cy     = (a != 8'h00);
                ov     = (a == 8'h80);
                hc     = result[3] | a[3];
                def_h  = 1'b1;
            end
            CAFR_OP_LSR, CAFR_OP_ROR, CAFR_OP_ASR: begin
                result = {(op == CAFR_OP_ROR) ? flags_in[FLAG_C] :
                          (op == CAFR_OP_ASR) ? a[7] : 1'b0, a[7:1]};
                cy     = a[0];
                ov     = result[7] ^ a[0];
            end
            CAFR_OP_SWAP: result = {a[3:0], a[7:4]};
        endcase
    end

    always_comb begin
        flags_out = flags_in;
        if (op != CAFR_OP_MOV && op != CAFR_OP_SWAP) begin
            flags_out[FLAG_N] = result[7];
            flags_out[FLAG_Z] = keep_z ? (flags_in[FLAG_Z] &
                                          (result == 8'h00))
                                       : (result == 8'h00);
            flags_out[FLAG_V] = ov;
            flags_out[FLAG_S] = result[7] ^ ov;
            if (op != CAFR_OP_INC && op != CAFR_OP_DEC &&
                op != CAFR_OP_AND && op != CAFR_OP_OR &&
                op != CAFR_OP_XOR) begin
                flags_out[FLAG_C] = cy;
            end
            if (def_h) begin
                flags_out[FLAG_H] = hc;
            end
        end
    end

endmodule // cafr_alu

// *** rtl/cafr_core.sv ***
// Datapath core: register file, flag register, pointers, data-space port
`timescale 1ns/1ps

module cafr_core
    import cafr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        alu_en,
    input  wire cafr_op_t    alu_op,
    input  wire logic [4:0]  rd_sel,
    input  wire logic [4:0]  rr_sel,
    input  wire logic        use_imm,
    input  wire logic [7:0]  imm,
    input  wire logic        wide_wr_en,
    input  wire logic [15:0] wide_wr_data,
    input  wire logic        bit_store_insn,
    input  wire logic        bit_load_insn,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        set_irq_insn,
    input  wire logic        clear_irq_insn,
    input  wire logic        irq_taken,
    input  wire logic        irq_return_insn,
    input  wire logic        irq_request,
    input  wire cafr_ptr_t   ptr_sel,
    input  wire cafr_ptrmode_t ptr_mode,
    input  wire logic [5:0]  ptr_disp,
    input  wire logic        indirect_load_insn,
    input  wire logic        indirect_store_insn,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic        port_rd,
    input  wire logic        port_wr,
    input  wire logic [5:0]  port_addr,
    output logic      [7:0]  rd_data,
    output logic      [7:0]  rr_data,
    output logic      [15:0] pair_data,
    output logic      [15:0] ptr_addr,
    output logic      [7:0]  mem_rdata,
    output logic             mem_hit,
    output logic      [7:0]  cpu_flags,
    output logic             irq_accept
);

    logic [7:0]  regs_ff [NUM_REGS];
    logic [7:0]  flags_ff;
    logic [7:0]  nxt_flags;
    logic [7:0]  op_b;
    logic [7:0]  alu_res;
    logic [7:0]  alu_flags;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [4:0]  ptr_low;
    logic [15:0] eff_addr;
    logic [15:0] port_as_data;
    logic        acc_rd;
    logic        acc_wr;
    logic        reg_hit;
    logic        flags_hit;
    logic [7:0]  bit_load_val;

    // ****************************************************************
    // Operand fetch and ALU
    // ****************************************************************

    assign rd_data   = regs_ff[rd_sel];
    assign rr_data   = regs_ff[rr_sel];
    assign pair_data = {regs_ff[{rd_sel[4:1], 1'b1}],
                        regs_ff[{rd_sel[4:1], 1'b0}]};
    assign op_b      = use_imm ? imm : rr_data;
    assign cpu_flags = flags_ff;

    cafr_alu u_alu (
        .op        (alu_op),
        .a         (rd_data),
        .b         (op_b),
        .flags_in  (flags_ff),
        .result    (alu_res),
        .flags_out (alu_flags)
    );

    // ****************************************************************
    // Pointers and data-space decode
    // ****************************************************************

    always_comb begin
        ptr_low = PTR_A_LOW;
        unique case (ptr_sel)
            CAFR_PTR_A:    ptr_low = PTR_A_LOW;
            CAFR_PTR_B:    ptr_low = PTR_B_LOW;
            CAFR_PTR_C:    ptr_low = PTR_C_LOW;
            CAFR_PTR_NONE: ptr_low = PTR_A_LOW;
        endcase
    end

    assign ptr_val = {regs_ff[ptr_low + 5'd1], regs_ff[ptr_low]};

    always_comb begin
        ptr_new  = ptr_val;
        eff_addr = ptr_val;
        unique case (ptr_mode)
            CAFR_PM_DISP:    eff_addr = ptr_val + {10'h000, ptr_disp};
            CAFR_PM_POSTINC: ptr_new  = ptr_val + 16'h0001;
            CAFR_PM_PREDEC: begin
                ptr_new  = ptr_val - 16'h0001;
                eff_addr = ptr_new;
            end
            default: eff_addr = ptr_val;
        endcase
    end

    logic ptr_act;
    assign ptr_act  = (indirect_load_insn | indirect_store_insn)
                    & (ptr_sel != CAFR_PTR_NONE);
    assign ptr_addr = ptr_act ? eff_addr : mem_addr;

    assign port_as_data = {10'h000, port_addr} + ADDR_PORT_OFS;
    assign acc_rd = mem_rd | port_rd;
    assign acc_wr = mem_wr | port_wr;

    logic [15:0] acc_addr;
    assign acc_addr = (port_rd | port_wr) ? port_as_data : ptr_addr;

    assign reg_hit   = (acc_addr <= ADDR_REG_LAST);
    assign flags_hit = (acc_addr == ADDR_FLAGS_DATA);
    assign mem_hit   = (acc_rd | acc_wr) & (reg_hit | flags_hit);

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_rdata <= 8'h00;
        end else if (acc_rd) begin
            if (reg_hit) begin
                mem_rdata <= regs_ff[acc_addr[4:0]];
            end else if (flags_hit) begin
                mem_rdata <= flags_ff;
            end else begin
                mem_rdata <= 8'h00;
            end
        end
    end

    // ****************************************************************
    // Register file write
    // ****************************************************************

    always_comb begin
        bit_load_val = rd_data;
        bit_load_val[bit_sel] = flags_ff[FLAG_T];
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clk) begin
                if (rst) begin
                    regs_ff[gi] <= 8'h00;
                end else if (acc_wr && reg_hit &&
                             acc_addr[4:0] == 5'(gi)) begin
                    regs_ff[gi] <= mem_wdata;
                end else if (wide_wr_en &&
                             rd_sel[4:1] == 4'(gi / 2)) begin
                    regs_ff[gi] <= (gi % 2 == 1) ? wide_wr_data[15:8]
                                                  : wide_wr_data[7:0];
                end else if (ptr_act && ptr_mode != CAFR_PM_DISP &&
                             ptr_low[4:1] == 4'(gi / 2)) begin
                    regs_ff[gi] <= (gi % 2 == 1) ? ptr_new[15:8]
                                                  : ptr_new[7:0];
                end else if (alu_en && rd_sel == 5'(gi)) begin
                    regs_ff[gi] <= alu_res;
                end else if (bit_load_insn && rd_sel == 5'(gi)) begin
                    regs_ff[gi] <= bit_load_val;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Flag register
    // ****************************************************************

    always_comb begin
        nxt_flags = alu_en ? alu_flags : flags_ff;
        if (bit_store_insn) begin
            nxt_flags[FLAG_T] = rd_data[bit_sel];
        end
        if (acc_wr && flags_hit) begin
            nxt_flags = mem_wdata;
        end
        if (set_irq_insn) begin
            nxt_flags[FLAG_I] = 1'b1;
        end
        if (clear_irq_insn) begin
            nxt_flags[FLAG_I] = 1'b0;
        end
        if (irq_return_insn) begin
            nxt_flags[FLAG_I] = 1'b1;
        end
        if (irq_taken) begin
            nxt_flags[FLAG_I] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_ff <= FLAGS_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign irq_accept = irq_request & flags_ff[FLAG_I];

    // ****************************************************************
    // Checks
    // ****************************************************************

    AST_SIGN_XOR: assert property (@(posedge clk) disable iff (rst)
        alu_en && !(acc_wr && flags_hit) && alu_op != CAFR_OP_MOV &&
        alu_op != CAFR_OP_SWAP |=> flags_ff[FLAG_S] ==
        (flags_ff[FLAG_N] ^ flags_ff[FLAG_V]))
        else $error("sign flag not N xor V");

    AST_ZERO: assert property (@(posedge clk) disable iff (rst)
        alu_en && alu_op == CAFR_OP_AND && !(acc_wr && flags_hit)
        |=> flags_ff[FLAG_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");

    AST_NEG: assert property (@(posedge clk) disable iff (rst)
        alu_en && alu_op == CAFR_OP_XOR && !(acc_wr && flags_hit)
        |=> flags_ff[FLAG_N] == $past(alu_res[7]))
        else $error("negative flag wrong");

    AST_WB: assert property (@(posedge clk) disable iff (rst)
        alu_en && !wide_wr_en && !acc_wr && !ptr_act
        |=> regs_ff[$past(rd_sel)] == $past(alu_res))
        else $error("ALU result not written back");

    AST_IRQ_GATE: assert property (@(posedge clk) disable iff (rst)
        !flags_ff[FLAG_I] |-> !irq_accept)
        else $error("interrupt accepted while disabled");

    AST_IRQ_TAKEN: assert property (@(posedge clk) disable iff (rst)
        irq_taken |=> !flags_ff[FLAG_I] ##1 (flags_ff[FLAG_I] ||
        !$past(irq_return_insn) || $past(irq_taken)))
        else $error("global enable not cleared on entry");

    AST_SEI: assert property (@(posedge clk) disable iff (rst)
        set_irq_insn && !clear_irq_insn && !irq_taken |=> flags_ff[FLAG_I])
        else $error("set-irq did not set enable");

    AST_BST: assert property (@(posedge clk) disable iff (rst)
        bit_store_insn && !(acc_wr && flags_hit)
        |=> flags_ff[FLAG_T] == $past(rd_data[bit_sel]))
        else $error("bit-store did not copy");

    AST_FLAG_WR: assert property (@(posedge clk) disable iff (rst)
        port_wr && port_addr == PORT_LAST && !set_irq_insn &&
        !clear_irq_insn && !irq_taken && !irq_return_insn
        |=> flags_ff == $past(mem_wdata))
        else $error("port write to flags failed");

    AST_EXT_NOPORT: assert property (@(posedge clk) disable iff (rst)
        (port_rd || port_wr) |-> acc_addr < ADDR_EXT_FIRST)
        else $error("port access reached extended space");

endmodule // cafr_core

// *** test/cafr_seq_model.sv ***
// Sequencer-side model that issues instructions to the datapath core
`timescale 1ns/1ps

module cafr_seq_model
    import cafr_pkg::*;
(
    input  wire logic     clk,
    output logic          alu_en,
    output cafr_op_t      alu_op,
    output logic [4:0]    rd_sel,
    output logic [4:0]    rr_sel,
    output logic          use_imm,
    output logic [7:0]    imm,
    output logic          wide_wr_en,
    output logic [15:0]   wide_wr_data,
    output logic          bit_store_insn,
    output logic          bit_load_insn,
    output logic [2:0]    bit_sel,
    output logic          set_irq_insn,
    output logic          clear_irq_insn,
    output logic          irq_taken,
    output logic          irq_return_insn,
    output logic          irq_request,
    output cafr_ptr_t     ptr_sel,
    output cafr_ptrmode_t ptr_mode,
    output logic [5:0]    ptr_disp,
    output logic          indirect_load_insn,
    output logic          indirect_store_insn,
    output logic          mem_rd,
    output logic          mem_wr,
    output logic [15:0]   mem_addr,
    output logic [7:0]    mem_wdata,
    output logic          port_rd,
    output logic          port_wr,
    output logic [5:0]    port_addr
);

    // Request starts high; the irq task moves it to test both gates
    initial begin
        {alu_en, rd_sel, rr_sel, use_imm, imm, wide_wr_en} = '0;
        {wide_wr_data, bit_store_insn, bit_load_insn, bit_sel} = '0;
        {set_irq_insn, clear_irq_insn, irq_taken, irq_return_insn} = '0;
        {ptr_disp, indirect_load_insn, indirect_store_insn} = '0;
        {mem_rd, mem_wr, mem_addr, mem_wdata, port_rd, port_wr} = '0;
        port_addr = 6'h00;
        alu_op = CAFR_OP_ADD;
        ptr_sel = CAFR_PTR_NONE;
        ptr_mode = CAFR_PM_DISP;
        irq_request = 1'b1;
    end

    // ***************************************************
    // Instruction issue: drive after an edge, drop at next
    // ***************************************************
    task automatic fin();
        @(posedge clk);
        {alu_en, wide_wr_en, bit_store_insn, bit_load_insn} <= 4'h0;
        {set_irq_insn, clear_irq_insn, irq_taken, irq_return_insn} <= 4'h0;
        {indirect_load_insn, indirect_store_insn, mem_rd, mem_wr} <= 4'h0;
        {port_rd, port_wr} <= 2'h0;
        // Released data inverted, never a stale copy
        mem_wdata <= ~mem_wdata;
        #1;
    endtask

    task automatic alu(input cafr_op_t op, input logic [4:0] d,
                       input logic [4:0] s, input logic ui,
                       input logic [7:0] k);
        @(posedge clk);
        alu_en  <= 1'b1;
        alu_op  <= op;
        rd_sel  <= d;
        rr_sel  <= s;
        use_imm <= ui;
        imm     <= k;
        #1;
    endtask

    task automatic mem(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        mem_rd    <= ~w;
        mem_wr    <= w;
        mem_addr  <= a;
        mem_wdata <= d;
        #1;
    endtask

    task automatic port(input logic w, input logic [5:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        port_rd   <= ~w;
        port_wr   <= w;
        port_addr <= a;
        mem_wdata <= d;
        #1;
    endtask

    // software owns flags
    // Nothing here expects flags restored after the return pulse
    task automatic irq(input logic [3:0] v);
        @(posedge clk);
        {set_irq_insn, clear_irq_insn, irq_taken, irq_return_insn} <= v;
        irq_request <= v[3] | v[2];
        #1;
    endtask

    task automatic bits(input logic st, input logic ld,
                        input logic [4:0] d, input logic [2:0] b);
        @(posedge clk);
        bit_store_insn <= st;
        bit_load_insn  <= ld;
        rd_sel         <= d;
        bit_sel        <= b;
        #1;
    endtask

    task automatic wide(input logic [4:0] d, input logic [15:0] v);
        @(posedge clk);
        wide_wr_en   <= 1'b1;
        rd_sel       <= d;
        wide_wr_data <= v;
        #1;
    endtask

    task automatic ptr(input cafr_ptr_t p, input cafr_ptrmode_t m,
                       input logic [5:0] dd);
        @(posedge clk);
        // Post-increment goes out as a store so both strobes are used
        indirect_load_insn  <= (m != CAFR_PM_POSTINC);
        indirect_store_insn <= (m == CAFR_PM_POSTINC);
        ptr_sel             <= p;
        ptr_mode            <= m;
        ptr_disp            <= dd;
        #1;
    endtask

endmodule // cafr_seq_model

// *** test/test_cafr_core.sv ***
// Self-checking bench for the datapath core
`timescale 1ns/1ps

module test_cafr_core import cafr_pkg::*;;

    logic clk, rst, alu_en, use_imm, wide_wr_en, bit_store_insn;
    logic bit_load_insn, set_irq_insn, clear_irq_insn, irq_taken;
    logic irq_return_insn, irq_request, indirect_load_insn;
    logic indirect_store_insn, mem_rd, mem_wr, port_rd, port_wr;
    logic mem_hit, irq_accept;
    logic [2:0] bit_sel;
    logic [4:0] rd_sel, rr_sel;
    logic [5:0] ptr_disp, port_addr, dd;
    logic [7:0] imm, mem_wdata, rd_data, rr_data, mem_rdata, cpu_flags;
    logic [7:0] exp_f, ef, er, k;
    logic [7:0] exp_r [32];
    logic [15:0] wide_wr_data, mem_addr, pair_data, ptr_addr, base, ea;
    logic [4:0] d, s;
    logic ui;
    cafr_op_t alu_op, op;
    cafr_ptr_t ptr_sel;
    cafr_ptrmode_t ptr_mode;
    int err_count, n_tests;
    integer seed = 32'h0000_be61;
    cafr_op_t ops [9] = '{CAFR_OP_ADD, CAFR_OP_ADC, CAFR_OP_SUB,
                          CAFR_OP_SBC, CAFR_OP_AND, CAFR_OP_OR,
                          CAFR_OP_XOR, CAFR_OP_MOV, CAFR_OP_SWAP};
    logic [3:0] ivec [4] = '{4'h8, 4'h2, 4'h1, 4'h4};

    cafr_seq_model u_cafr_seq_model (.*);

    cafr_core u_cafr_core (.*);

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Flags S V N Z from result; C H only where the op defines them
    function automatic logic [15:0] alu_ref(cafr_op_t o, logic [7:0] a,
                                            logic [7:0] b, logic [7:0] f);
        logic [8:0] t;
        logic [4:0] h;
        logic [7:0] r;
        logic       ci;
        logic       ar;
        logic       sb;
        ar = (o == CAFR_OP_ADD || o == CAFR_OP_ADC);
        sb = (o == CAFR_OP_SUB || o == CAFR_OP_SBC);
        ci = (o == CAFR_OP_ADC || o == CAFR_OP_SBC) & f[FLAG_C];
        h = 5'h00;
        case (o)
            CAFR_OP_AND:  t = {1'b0, a & b};
            CAFR_OP_OR:   t = {1'b0, a | b};
            CAFR_OP_XOR:  t = {1'b0, a ^ b};
            CAFR_OP_MOV:  t = {1'b0, b};
            CAFR_OP_SWAP: t = {1'b0, a[3:0], a[7:4]};
            default: begin
                // Nibble sum gives the carry or borrow out of bit 3
                t = sb ? {1'b0, a} - {1'b0, b} - 9'(ci)
                       : {1'b0, a} + {1'b0, b} + 9'(ci);
                h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci)
                       : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
            end
        endcase
        r = t[7:0];
        if (o == CAFR_OP_MOV || o == CAFR_OP_SWAP) begin
            return {f, r};
        end
        f[FLAG_N] = r[7];
        // Carry-chained subtract only keeps a zero already there
        f[FLAG_Z] = (r == 8'h00) && (o != CAFR_OP_SBC || f[FLAG_Z]);
        f[FLAG_V] = 1'b0;
        if (ar || sb) begin
            f[FLAG_C] = t[8];
            f[FLAG_H] = h[4];
            f[FLAG_V] = (r[7] != a[7]) && ((a[7] == b[7]) == ar);
        end
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        return {f, r};
    endfunction

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Run takes a few hundred cycles; this bounds a hang
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    // *******************************************
    // Main sequence
    // *******************************************
    initial begin
        rst = 1'b1;
        exp_f = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("flags reset", 16'(cpu_flags), 16'h0000);
        for (int i = 0; i < NUM_REGS; i++) begin
            exp_r[i] = (i == 16) ? 8'h7F : 8'($random(seed));
            u_cafr_seq_model.mem(1'b1, 16'(i), exp_r[i]);
            check("reg hit", 16'(mem_hit), 16'h0001);
            u_cafr_seq_model.fin();
        end
        for (int i = 0; i < NUM_REGS; i++) begin
            u_cafr_seq_model.mem(1'b0, 16'(i), 8'h00);
            u_cafr_seq_model.fin();
            check("reg data", 16'(mem_rdata), 16'(exp_r[i]));
        end
        // Two hand-made corners first: overflow into sign, zero borrow
        for (int i = 0; i < 60; i++) begin
            op = ops[$unsigned($random(seed)) % 9];
            d = 5'($random(seed));
            s = 5'($random(seed));
            ui = 1'($random(seed));
            k = 8'($random(seed));
            if (i < 2) begin
                op = (i == 0) ? CAFR_OP_ADD : CAFR_OP_SUB;
                {d, ui, k} = {5'd16, 1'b1, (i == 0) ? 8'h01 : 8'h80};
            end
            {ef, er} = alu_ref(op, exp_r[d], ui ? k : exp_r[s], exp_f);
            u_cafr_seq_model.alu(op, d, s, ui, k);
            check("operand a", 16'(rd_data), 16'(exp_r[d]));
            check("operand b", 16'(rr_data), 16'(exp_r[s]));
            u_cafr_seq_model.fin();
            exp_r[d] = er;
            exp_f = ef;
            check("alu result", 16'(rd_data), 16'(er));
            check("alu flags", 16'(cpu_flags), 16'(ef));
        end
        u_cafr_seq_model.mem(1'b1, ADDR_FLAGS_DATA, 8'hB5);
        check("flag hit", 16'(mem_hit), 16'h0001);
        u_cafr_seq_model.fin();
        check("flags data wr", 16'(cpu_flags), 16'h00B5);
        check("accept on", 16'(irq_accept), 16'h0001);
        u_cafr_seq_model.port(1'b1, PORT_LAST, 8'h5A);
        u_cafr_seq_model.fin();
        check("flags port wr", 16'(cpu_flags), 16'h005A);
        check("accept off", 16'(irq_accept), 16'h0000);
        u_cafr_seq_model.port(1'b0, PORT_LAST, 8'h00);
        u_cafr_seq_model.fin();
        check("flags port rd", 16'(mem_rdata), 16'h005A);
        exp_f = 8'h5A;
        for (int i = 0; i < 4; i++) begin
            u_cafr_seq_model.irq(ivec[i]);
            u_cafr_seq_model.fin();
            exp_f[FLAG_I] = ~i[0];
            check("irq enable", 16'(cpu_flags), 16'(exp_f));
            ui = exp_f[FLAG_I] & (ivec[i][3:2] != 2'b00);
            check("irq gate", 16'(irq_accept), 16'(ui));
        end
        for (int i = 0; i < 8; i++) begin
            u_cafr_seq_model.bits(1'b1, 1'b0, 5'd5, 3'(i));
            u_cafr_seq_model.fin();
            exp_f[FLAG_T] = exp_r[5][i];
            check("copy flag", 16'(cpu_flags), 16'(exp_f));
            u_cafr_seq_model.bits(1'b0, 1'b1, 5'd6, 3'(7 - i));
            u_cafr_seq_model.fin();
            exp_r[6][7 - i] = exp_f[FLAG_T];
            check("bit load", 16'(rd_data), 16'(exp_r[6]));
        end
        u_cafr_seq_model.mem(1'b1, ADDR_EXT_FIRST, 8'hFF);
        check("ext hit", 16'(mem_hit), 16'h0000);
        u_cafr_seq_model.fin();
        u_cafr_seq_model.mem(1'b0, ADDR_EXT_FIRST, 8'h00);
        u_cafr_seq_model.fin();
        check("ext read", 16'(mem_rdata), 16'h0000);
        // Pointer A starts at all ones so increment wraps
        for (int p = 0; p < 3; p++) begin
            base = (p == 0) ? 16'hFFFF : 16'($random(seed));
            u_cafr_seq_model.wide(PTR_A_LOW + 5'(2 * p), base);
            u_cafr_seq_model.fin();
            check("pair", pair_data, base);
            u_cafr_seq_model.mem(1'b0, 16'(PTR_A_LOW) + 16'(2 * p + 1), 8'h00);
            u_cafr_seq_model.fin();
            check("ptr high", 16'(mem_rdata), 16'(base[15:8]));
            for (int m = 0; m < 3; m++) begin
                dd = 6'($random(seed));
                u_cafr_seq_model.ptr(cafr_ptr_t'(p), cafr_ptrmode_t'(m), dd);
                ea = (m == 0) ? base + 16'(dd) :
                     (m == 1) ? base : base - 16'h1;
                check("ptr addr", ptr_addr, ea);
                u_cafr_seq_model.fin();
                base = (m == 0) ? base : (m == 1) ? base + 16'h1 : ea;
                check("ptr value", pair_data, base);
            end
        end
        u_cafr_seq_model.ptr(CAFR_PTR_NONE, CAFR_PM_PREDEC, 6'h00);
        check("no ptr", ptr_addr, mem_addr);
        u_cafr_seq_model.fin();
        check("no ptr keep", pair_data, base);
        wrap_up();
    end

endmodule // test_cafr_core
